// >>> tcr_defs.vh
// constants for the transceive control register block
`ifndef TCR_DEFS_VH
`define TCR_DEFS_VH

// register word indices
`define TCR_IRQ_ENABLE_ADDR 4'h1
`define TCR_IRQ_STATUS_ADDR 4'h2
`define TCR_IRQ_CLEAR_ADDR 4'h3
`define TCR_CTRL_ADDR 4'h4

// control register fields
`define TCR_SEL_MSB 9
`define TCR_SEL_LSB 4
`define TCR_SKIP_BIT 3
`define TCR_PER_BYTE_BIT 2
`define TCR_RX_REPEAT_BIT 1
`define TCR_INITIATOR_BIT 0
`define TCR_CTRL_RESET 10'h000

// interrupt bit position of the state-change event
`define TCR_STATE_IRQ_BIT 5

// sequencer state codes
`define TCR_ST_IDLE 3'h0
`define TCR_ST_TX_WAIT 3'h1
`define TCR_ST_TX 3'h2
`define TCR_ST_RX_WAIT 3'h3
`define TCR_ST_DATA_WAIT 3'h4
`define TCR_ST_RX 3'h5

// transmit symbol kinds
`define TCR_SYM_SOF 2'h0
`define TCR_SYM_DATA 2'h1
`define TCR_SYM_EOF 2'h2

`endif

// >>> tcr_tx_framer.v
// transmit framer that feeds start, data and end symbols to the encoder
`timescale 1ns/100ps
`default_nettype none
`include "tcr_defs.vh"
module tcr_tx_framer (
  // clock and reset
  input wire clk_sys,
  input wire rst_n,
  // control
  input wire tx_go,
  input wire per_byte_frame_enable,
  output wire tx_busy,
  // byte source
  input wire src_valid,
  input wire [7:0] src_data,
  input wire src_last,
  output wire src_ready,
  // encoder side
  output reg sym_valid,
  output reg [1:0] sym_kind,
  output reg [7:0] sym_data,
  input wire sym_ready
);
  localparam S_IDLE = 2'h0;
  localparam S_DATA = 2'h1;
  localparam S_EOF = 2'h2;
  localparam S_STEP = 2'h3;

  reg [1:0] state_q;
  reg last_q;
  reg go_hold_q;

  // a symbol slot is free when empty or being taken this cycle
  wire slot_free = ~sym_valid | sym_ready;
  assign src_ready = (state_q == S_DATA) & slot_free;
  assign tx_busy = (state_q != S_IDLE);

  // sequencing of frame symbols
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      state_q <= S_IDLE;
      last_q <= 1'b0;
      go_hold_q <= 1'b0;
      sym_valid <= 1'b0;
      sym_kind <= `TCR_SYM_SOF;
      sym_data <= 8'h00;
    end else begin
      if (sym_valid & sym_ready) begin
        sym_valid <= 1'b0;
      end
      case (state_q)
        S_IDLE, S_STEP: begin
          // a fresh trigger opens a frame; in step mode this resumes after a byte
          if ((tx_go | go_hold_q) & slot_free) begin
            go_hold_q <= 1'b0;
            sym_valid <= 1'b1;
            sym_kind <= `TCR_SYM_SOF;
            sym_data <= 8'h00;
            state_q <= S_DATA;
          end else if (tx_go) begin
            // the trigger is a one-cycle pulse; held here so a stalled end symbol cannot eat it
            go_hold_q <= 1'b1;
          end
        end
        S_DATA: begin
          if (src_valid & slot_free) begin
            sym_valid <= 1'b1;
            sym_kind <= `TCR_SYM_DATA;
            sym_data <= src_data;
            last_q <= src_last;
            // one byte per frame in step mode, else close after the last
            if (per_byte_frame_enable | src_last) begin
              state_q <= S_EOF;
            end
          end
        end
        S_EOF: begin
          if (slot_free) begin
            sym_valid <= 1'b1;
            sym_kind <= `TCR_SYM_EOF;
            sym_data <= 8'h00;
            // stall for a new trigger unless the buffer is exhausted
            state_q <= (per_byte_frame_enable & ~last_q) ? S_STEP : S_IDLE;
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> tcr_rx_store.v
// packs received bytes into aligned RAM words, with per-frame status in repeat mode
`timescale 1ns/100ps
`default_nettype none
`include "tcr_defs.vh"
module tcr_rx_store (
  // clock and reset
  input wire clk_sys,
  input wire rst_n,
  // control
  input wire rx_repeat_enable,
  input wire rx_begin,
  // receiver side
  input wire rx_byte_valid,
  input wire [7:0] rx_byte,
  input wire rx_end,
  input wire [7:0] rx_status,
  // RAM side
  output reg ram_we,
  output reg [7:0] ram_addr,
  output reg [31:0] ram_wdata
);
  reg [31:0] word_q;
  reg [1:0] lane_q;
  reg [7:0] addr_q;
  reg flush_q;

  // status byte joins the packer as the frame's final byte in repeat mode
  wire status_in = rx_end & rx_repeat_enable;
  wire byte_in = rx_byte_valid | status_in;
  wire [7:0] byte_val = status_in ? rx_status : rx_byte;

  // place a byte in its lane; lanes above stay zero
  function [31:0] tcr_put;
    input [31:0] word;
    input [1:0] lane;
    input [7:0] val;
    begin
      tcr_put = word;
      tcr_put[lane * 8 +: 8] = val;
    end
  endfunction

  wire [31:0] next_word = tcr_put(word_q, lane_q, byte_val);

  // packing, flushing and address stepping
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      word_q <= 32'h00000000;
      lane_q <= 2'h0;
      addr_q <= 8'h00;
      flush_q <= 1'b0;
      ram_we <= 1'b0;
      ram_addr <= 8'h00;
      ram_wdata <= 32'h00000000;
    end else begin
      ram_we <= 1'b0;
      flush_q <= rx_end;
      if (rx_begin) begin
        // a fresh, non-continued reception starts at the buffer base
        addr_q <= 8'h00;
        lane_q <= 2'h0;
        word_q <= 32'h00000000;
      end else if (byte_in) begin
        if (lane_q == 2'h3) begin
          ram_we <= 1'b1;
          ram_addr <= addr_q;
          ram_wdata <= next_word;
          addr_q <= addr_q + 8'h01;
          word_q <= 32'h00000000;
        end else begin
          word_q <= next_word;
        end
        lane_q <= lane_q + 2'h1;
      end else if (flush_q && lane_q != 2'h0) begin
        // partial word goes out with zero bytes in its empty lanes
        ram_we <= 1'b1;
        ram_addr <= addr_q;
        ram_wdata <= word_q;
        addr_q <= addr_q + 8'h01;
        word_q <= 32'h00000000;
        lane_q <= 2'h0;
      end
    end
  end
endmodule
`default_nettype wire

// >>> tcr_top.v
// transceive control register with state trigger, framing and reception options
`timescale 1ns/100ps
`default_nettype none
`include "tcr_defs.vh"
module tcr_top (
  // clock and reset
  input wire clk_sys,
  input wire rst_n,
  // register port
  input wire [3:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  // sequencer state, same clock
  input wire [2:0] seq_state,
  // transmit request
  input wire tx_delay_done,
  input wire tx_send_req,
  // transmit byte source
  input wire src_valid,
  input wire [7:0] src_data,
  input wire src_last,
  output wire src_ready,
  // encoder symbols
  output wire sym_valid,
  output wire [1:0] sym_kind,
  output wire [7:0] sym_data,
  input wire sym_ready,
  output wire tx_busy,
  // receiver
  input wire rx_byte_valid,
  input wire [7:0] rx_byte,
  input wire rx_end,
  input wire [7:0] rx_status,
  input wire rx_begin,
  output reg rx_rearm,
  // RAM write port
  output wire ram_we,
  output wire [7:0] ram_addr,
  output wire [31:0] ram_wdata,
  // role and interrupt
  output wire contactless_frontend_initiator,
  output wire transceive_tx_first,
  output wire irq_state_change
);
  reg [9:0] ctrl_q;
  reg [9:0] ctrl_d;
  reg irq_en_q;
  reg flag_q;
  reg [2:0] prev_state_q;
  reg go_cond_q;

  // address match helper used for both reads and writes
  function tcr_hit;
    input [3:0] addr;
    input [3:0] target;
    begin
      tcr_hit = (addr == target);
    end
  endfunction

  // one-hot of the current state, in select-field order
  function [5:0] tcr_state_onehot;
    input [2:0] st;
    begin
      case (st)
        `TCR_ST_IDLE: tcr_state_onehot = 6'h01;
        `TCR_ST_TX_WAIT: tcr_state_onehot = 6'h02;
        `TCR_ST_TX: tcr_state_onehot = 6'h04;
        `TCR_ST_RX_WAIT: tcr_state_onehot = 6'h08;
        `TCR_ST_DATA_WAIT: tcr_state_onehot = 6'h10;
        `TCR_ST_RX: tcr_state_onehot = 6'h20;
        default: tcr_state_onehot = 6'h00;
      endcase
    end
  endfunction

  wire wr_ctrl = reg_wr & tcr_hit(reg_addr, `TCR_CTRL_ADDR);
  wire wr_en = reg_wr & tcr_hit(reg_addr, `TCR_IRQ_ENABLE_ADDR);
  wire wr_clr = reg_wr & tcr_hit(reg_addr, `TCR_IRQ_CLEAR_ADDR);

  wire [5:0] sel = ctrl_q[`TCR_SEL_MSB:`TCR_SEL_LSB];
  wire skip_en = ctrl_q[`TCR_SKIP_BIT];
  wire step_en = ctrl_q[`TCR_PER_BYTE_BIT];
  wire repeat_en = ctrl_q[`TCR_RX_REPEAT_BIT];
  wire initiator = ctrl_q[`TCR_INITIATOR_BIT];

  // a state is entered when the code differs from last cycle
  wire state_entered = (seq_state != prev_state_q);
  wire [5:0] entered_oh = state_entered ? tcr_state_onehot(seq_state) : 6'h00;
  // zero select bits can never match, so no flag without selection
  wire state_hit = |(entered_oh & sel);
  wire enter_rx_wait = state_entered & (seq_state == `TCR_ST_RX_WAIT);

  // start condition, gated by suppression, turned into one trigger pulse
  wire go_cond = tx_delay_done & tx_send_req & ~skip_en;
  wire tx_go = go_cond & ~go_cond_q;

  // control register next value; hardware clear of suppression wins
  always @* begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      ctrl_d = reg_wdata[9:0];
    end
    if (enter_rx_wait) begin
      ctrl_d[`TCR_SKIP_BIT] = 1'b0;
    end
  end

  // register state
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl_q <= `TCR_CTRL_RESET;
      irq_en_q <= 1'b0;
      flag_q <= 1'b0;
      prev_state_q <= `TCR_ST_IDLE;
      go_cond_q <= 1'b0;
      rx_rearm <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      prev_state_q <= seq_state;
      go_cond_q <= go_cond;
      // re-arm the receiver after each finished frame in repeat mode
      rx_rearm <= rx_end & repeat_en;
      if (wr_en) begin
        irq_en_q <= reg_wdata[`TCR_STATE_IRQ_BIT];
      end
      // sticky flag: a new event beats a clear in the same cycle
      if (state_hit) begin
        flag_q <= 1'b1;
      end else if (wr_clr & reg_wdata[`TCR_STATE_IRQ_BIT]) begin
        flag_q <= 1'b0;
      end
    end
  end

  // read data, valid only in the cycle after the strobe
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      reg_rdata <= 32'h00000000;
      if (tcr_hit(reg_addr, `TCR_CTRL_ADDR)) begin
        reg_rdata[9:0] <= ctrl_q;
      end else if (tcr_hit(reg_addr, `TCR_IRQ_ENABLE_ADDR)) begin
        reg_rdata[`TCR_STATE_IRQ_BIT] <= irq_en_q;
      end else if (tcr_hit(reg_addr, `TCR_IRQ_STATUS_ADDR)) begin
        reg_rdata[`TCR_STATE_IRQ_BIT] <= flag_q;
      end
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  // interrupt line gated by its enable
  assign irq_state_change = flag_q & irq_en_q;

  // role output; a target listens before it answers
  assign contactless_frontend_initiator = initiator;
  assign transceive_tx_first = initiator;

  // transmit framing
  tcr_tx_framer u_framer (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .tx_go(tx_go),
    .per_byte_frame_enable(step_en),
    .tx_busy(tx_busy),
    .src_valid(src_valid),
    .src_data(src_data),
    .src_last(src_last),
    .src_ready(src_ready),
    .sym_valid(sym_valid),
    .sym_kind(sym_kind),
    .sym_data(sym_data),
    .sym_ready(sym_ready)
  );

  // reception storage; the address keeps running across repeated frames
  tcr_rx_store u_store (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .rx_repeat_enable(repeat_en),
    .rx_begin(rx_begin),
    .rx_byte_valid(rx_byte_valid),
    .rx_byte(rx_byte),
    .rx_end(rx_end),
    .rx_status(rx_status),
    .ram_we(ram_we),
    .ram_addr(ram_addr),
    .ram_wdata(ram_wdata)
  );
endmodule
`default_nettype wire

// >>> tcr_asserts.sv
// port assertions for the transceive control block
`timescale 1ns/100ps
`default_nettype none
`include "tcr_defs.vh"
module tcr_asserts (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // sequencer and transmit
  input wire logic [2:0] seq_state,
  input wire logic tx_delay_done,
  input wire logic tx_send_req,
  input wire logic tx_busy,
  input wire logic src_valid,
  input wire logic [7:0] src_data,
  input wire logic src_ready,
  input wire logic sym_valid,
  input wire logic [1:0] sym_kind,
  input wire logic [7:0] sym_data,
  input wire logic sym_ready,
  // receive, role, interrupt
  input wire logic rx_end,
  input wire logic rx_rearm,
  input wire logic contactless_frontend_initiator,
  input wire logic irq_state_change
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // upper control bits never show on a read
  property p_rd_upper; $past(reg_rd) |-> reg_rdata[31:10] == 22'h0; endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("read data upper bits set");
  // the framer must never wake without a delay-done send request in the cycle before
  property p_tx_go; $rose(tx_busy) |-> $past(tx_delay_done && tx_send_req); endproperty
  a_tx_go: assert property (p_tx_go) else $error("framer started without request");
  // the flag needs a state entry, the output may also follow an enable write
  property p_irq_rise;
    $rose(irq_state_change) |-> $past(reg_wr) || ($past(seq_state) != $past(seq_state, 2));
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq without state entry");
  // only software ends the flag
  property p_irq_fall; $fell(irq_state_change) |-> $past(reg_wr); endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped on its own");
  // role follows the register only
  property p_role; $changed(contactless_frontend_initiator) |-> $past(reg_wr); endproperty
  a_role: assert property (p_role) else $error("role changed without write");
  // re-arm is a single pulse after a frame end
  property p_rearm; rx_rearm |-> $past(rx_end) ##1 !rx_rearm; endproperty
  a_rearm: assert property (p_rearm) else $error("re-arm without frame end");
  // every accepted byte becomes a data symbol next cycle
  property p_byte;
    src_valid && src_ready |=> sym_valid && sym_kind == `TCR_SYM_DATA && sym_data == $past(src_data);
  endproperty
  a_byte: assert property (p_byte) else $error("accepted byte not sent");
  // a stalled symbol holds still, so framing symbols cannot be lost
  property p_hold; sym_valid && !sym_ready |=> sym_valid && $stable(sym_kind) && $stable(sym_data);
  endproperty
  a_hold: assert property (p_hold) else $error("symbol changed while stalled");
endmodule
`default_nettype wire

// >>> tcr_tb.sv
// self-checking bench for the transceive control block
`timescale 1ns/100ps
`default_nettype none
`include "tcr_defs.vh"
module testbench;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [2:0] seq_state = 3'h0;
  logic tx_delay_done = 1'b0;
  logic tx_send_req = 1'b0;
  logic src_valid = 1'b0;
  logic [7:0] src_data = 8'h00;
  logic src_last = 1'b0;
  logic sym_ready = 1'b0;
  logic rx_byte_valid = 1'b0;
  logic [7:0] rx_byte = 8'h00;
  logic rx_end = 1'b0;
  logic [7:0] rx_status = 8'h00;
  logic rx_begin = 1'b0;
  wire logic [31:0] reg_rdata;
  wire logic [31:0] ram_wdata;
  wire logic [7:0] ram_addr;
  wire logic [7:0] sym_data;
  wire logic [1:0] sym_kind;
  wire logic src_ready, sym_valid, tx_busy, rx_rearm, ram_we;
  wire logic contactless_frontend_initiator, transceive_tx_first, irq_state_change;
  int errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int rearm_n = 0;
  int c;
  int nxt;
  logic [31:0] w;
  logic [7:0] b0, b1, rb, rs;
  logic [7:0] sq[$];
  logic [9:0] sym_q[$];
  logic [9:0] exp_q[$];
  logic [39:0] ram_q[$];

  tcr_top uut (.clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .seq_state, .tx_delay_done, .tx_send_req, .src_valid, .src_data, .src_last, .src_ready,
    .sym_valid, .sym_kind, .sym_data, .sym_ready, .tx_busy, .rx_byte_valid, .rx_byte,
    .rx_end, .rx_status, .rx_begin, .rx_rearm, .ram_we, .ram_addr, .ram_wdata,
    .contactless_frontend_initiator, .transceive_tx_first, .irq_state_change);

  // 25 MHz clock
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic end_sim();
    if (errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    step(1);
    reg_wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string what);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    step(1);
    reg_rd <= 1'b0;
    chk(what, exp, reg_rdata);
  endtask

  task automatic set_st(input int s);
    @(posedge clk_sys);
    seq_state <= 3'(s);
    #1;
  endtask

  task automatic wait_sym(input int n);
    while (sym_q.size() < n) step(1);
  endtask

  // monitors, byte source, random encoder stalls and the hang limit
  always @(posedge clk_sys) begin
    if (sym_valid && sym_ready) sym_q.push_back({sym_kind, sym_kind == 2'h1 ? sym_data : 8'h00});
    if (ram_we) ram_q.push_back({ram_addr, ram_wdata});
    if (rx_rearm) rearm_n++;
    if (src_valid && src_ready) void'(sq.pop_front());
    src_valid <= sq.size() != 0;
    src_data <= (sq.size() != 0) ? sq[0] : 8'h00;
    src_last <= sq.size() == 1;
    sym_ready <= 1'($urandom_range(1, 0));
    cyc++;
    if (cyc > 5000) begin
      errors++;
      end_sim();
    end
  end

  initial begin
    b0 = 8'($urandom(74));
    step(2);
    rst_n <= 1'b1;
    rd(4'h4, 32'h0, "ctrl reset");
    wr(4'h4, 32'hffffffff);
    rd(4'h4, 32'h3ff, "ctrl upper");
    rd(4'h6, 32'h0, "unmapped");
    chk("initiator", 32'h1, {31'h0, contactless_frontend_initiator});
    chk("tx first", 32'h1, {31'h0, transceive_tx_first});
    wr(4'h4, 32'h0);
    chk("tx first", 32'h0, {31'h0, transceive_tx_first});
    // one selected state at a time, entered from a neighbour
    wr(4'h1, 32'h20);
    for (c = 0; c < 6; c++) begin
      wr(4'h4, 32'h10 << c);
      set_st((c + 1) % 6);
      wr(4'h3, 32'h20);
      set_st(c);
      step(2);
      chk("irq entry", 32'h1, {31'h0, irq_state_change});
      rd(4'h2, 32'h20, "flag");
      wr(4'h3, 32'h20);
      chk("irq clear", 32'h0, {31'h0, irq_state_change});
    end
    // nothing selected: a full walk raises nothing
    wr(4'h4, 32'h0);
    for (c = 0; c < 6; c++) set_st(c);
    step(2);
    rd(4'h2, 32'h0, "no select");
    // masked event still sets the flag
    wr(4'h1, 32'h0);
    wr(4'h4, 32'h3f0);
    set_st($urandom_range(4, 0));
    step(2);
    chk("irq masked", 32'h0, {31'h0, irq_state_change});
    rd(4'h2, 32'h20, "masked flag");
    wr(4'h1, 32'h20);
    chk("irq unmasked", 32'h1, {31'h0, irq_state_change});
    wr(4'h3, 32'h20);
    wr(4'h4, 32'h0);
    set_st(0);
    // suppressed transmission in per-byte mode, released by rx wait
    wr(4'h4, 32'hc);
    b0 = 8'($urandom);
    b1 = 8'($urandom);
    sq.push_back(b0);
    sq.push_back(b1);
    exp_q = '{10'h000, {2'h1, b0}, 10'h200, 10'h000, {2'h1, b1}, 10'h200};
    tx_delay_done <= 1'b1;
    tx_send_req <= 1'b1;
    step(4);
    chk("tx held", 32'h0, 32'(sym_q.size()));
    set_st(3);
    step(2);
    rd(4'h4, 32'h4, "skip cleared");
    wait_sym(3);
    step(4);
    chk("byte stall", 32'h3, 32'(sym_q.size()));
    tx_send_req <= 1'b0;
    step(1);
    tx_send_req <= 1'b1;
    wait_sym(6);
    for (c = 0; c < 6; c++) chk("symbol", 32'(exp_q[c]), 32'(sym_q[c]));
    tx_delay_done <= 1'b0;
    tx_send_req <= 1'b0;
    // normal framing: both bytes travel in a single frame
    wr(4'h4, 32'h0);
    sq.push_back(b1);
    sq.push_back(b0);
    exp_q = '{10'h000, {2'h1, b1}, {2'h1, b0}, 10'h200};
    tx_delay_done <= 1'b1;
    tx_send_req <= 1'b1;
    wait_sym(10);
    for (c = 0; c < 4; c++) chk("frame symbol", 32'(exp_q[c]), 32'(sym_q[c + 6]));
    tx_delay_done <= 1'b0;
    tx_send_req <= 1'b0;
    // one-byte frame in repeat mode: byte, status, zero padding
    wr(4'h4, 32'h2);
    rb = 8'($urandom);
    rs = 8'($urandom);
    rx_begin <= 1'b1;
    step(1);
    rx_begin <= 1'b0;
    rx_byte_valid <= 1'b1;
    rx_byte <= rb;
    step(1);
    rx_byte_valid <= 1'b0;
    rx_end <= 1'b1;
    rx_status <= rs;
    step(1);
    rx_end <= 1'b0;
    step(6);
    chk("ram writes", 32'h1, 32'(ram_q.size()));
    chk("ram word", {16'h0, rs, rb}, ram_q[0][31:0]);
    chk("ram addr", 32'h0, {24'h0, ram_q[0][39:32]});
    chk("rearm", 32'h1, 32'(rearm_n));
    // second frame continues without rx_begin; software works out its start word
    w = {8'($urandom), 8'($urandom), 8'($urandom), 8'($urandom)};
    nxt = (1 + 1 + 3) / 4; // one data byte plus status, rounded up to whole words
    rx_byte_valid <= 1'b1;
    for (c = 0; c < 3; c++) begin
      rx_byte <= w[c * 8 +: 8];
      step(1);
    end
    rx_byte_valid <= 1'b0;
    rx_end <= 1'b1;
    rx_status <= w[31:24];
    step(1);
    rx_end <= 1'b0;
    step(6);
    chk("ram writes 2", 32'h2, 32'(ram_q.size()));
    chk("frame 2 word", w, ram_q[1][31:0]);
    chk("frame 2 addr", 32'(nxt), {24'h0, ram_q[1][39:32]});
    chk("rearm 2", 32'h2, 32'(rearm_n));
    // without repeat mode: no status byte, no re-arm, still zero padded
    wr(4'h4, 32'h0);
    rx_begin <= 1'b1;
    step(1);
    rx_begin <= 1'b0;
    rx_byte_valid <= 1'b1;
    rx_byte <= rb;
    step(1);
    rx_byte_valid <= 1'b0;
    rx_end <= 1'b1;
    step(1);
    rx_end <= 1'b0;
    step(6);
    chk("ram writes 3", 32'h3, 32'(ram_q.size()));
    chk("plain word", {24'h0, rb}, ram_q[2][31:0]);
    chk("plain addr", 32'h0, {24'h0, ram_q[2][39:32]});
    chk("rearm plain", 32'h2, 32'(rearm_n));
    end_sim();
  end
endmodule

bind tcr_top tcr_asserts u_chk (.clk_sys, .rst_n, .reg_wr, .reg_rd, .reg_rdata, .seq_state,
  .tx_delay_done, .tx_send_req, .tx_busy, .src_valid, .src_data, .src_ready, .sym_valid,
  .sym_kind, .sym_data, .sym_ready, .rx_end, .rx_rearm, .contactless_frontend_initiator,
  .irq_state_change);
`default_nettype wire
